// ---- hw/usnb_defs.svh ----
// constants and summary of operation for the serial ninth-bit and receive control block
// Summary of operation
// - modes 2/3: received ninth bit into flag
// - mode 1, check off: stop bit into flag
// - mode 0: received ninth-bit flag meaningless
// - rx fifo: flag shows oldest entry, refreshed per read
// - modes 2/3: send tx ninth bit
// - tx fifo: store ninth bit with byte
// - receive enable low: receiver accepts nothing
// - receive enable high: receive; mode 0 starts
// - mode 1, check on: drop bad stop
// - modes 2/3, check on: ninth zero suppressed
// - mode 0, check off: shift clock divides 12
`ifndef USNB_DEFS_SVH
`define USNB_DEFS_SVH
`define USNB_ADDR_CTRL     12'h000
`define USNB_ADDR_DATA     12'h004
`define USNB_ADDR_FCFG     12'h008
`define USNB_ADDR_STAT     12'h00C
`define USNB_ADDR_IEN      12'h010
`define USNB_ADDR_ICLR     12'h014
`define USNB_ADDR_TXDATA   12'h018
`define USNB_CTRL_RESET    8'h00
`define USNB_BIT_RXFLAG    0
`define USNB_BIT_TI        1
`define USNB_BIT_RX9       2
`define USNB_BIT_TX9       3
`define USNB_BIT_REN       4
`define USNB_BIT_MPCHK     5
`define USNB_BIT_SM1       6
`define USNB_BIT_SM0       7
`define USNB_BIT_RXFEN     0
`define USNB_BIT_TXFEN     1
`define USNB_EV_RX         0
`define USNB_EV_DROP       1
`define USNB_EV_TX         2
`define USNB_EV_M0START    3
`define USNB_DIV12         4'd12
`define USNB_DIV4          4'd4
`endif

// ---- hw/usnb_pkg.sv ----
// types for the serial ninth-bit and receive control block
package usnb_pkg;
  typedef enum logic [1:0] {USNB_M0, USNB_M1, USNB_M2, USNB_M3} usnb_mode_e;
  typedef logic [8:0] usnb_word_t;
endpackage : usnb_pkg

// ---- hw/usnb_fifo_if.sv ----
// push/pop handshake between the control logic and its word fifo
`timescale 1ns/1ps
`default_nettype none
interface usnb_fifo_if;
  import usnb_pkg::*;
  logic       push;
  usnb_word_t wdata;
  logic       pop;
  usnb_word_t rdata;
  logic       empty;
  logic       full;
  modport owner (output push, output wdata, output pop, input rdata, input empty, input full);
  modport fifo  (input push, input wdata, input pop, output rdata, output empty, output full);
endinterface : usnb_fifo_if
`default_nettype wire

// ---- hw/usnb_fifo.sv ----
// small word fifo carrying a data byte with its ninth bit
`timescale 1ns/1ps
`default_nettype none
module usnb_fifo #(
  parameter int DEPTH = 4
) (
  input wire logic mclk,     // system clock
  input wire logic rst,      // async reset
  usnb_fifo_if.fifo f        // push/pop side
);
  import usnb_pkg::*;
  localparam int AW = $clog2(DEPTH);
  usnb_word_t         mem [DEPTH];
  logic [AW-1:0]      wp_r;
  logic [AW-1:0]      rp_r;
  logic [AW:0]        cnt_r;
  logic               do_push;
  logic               do_pop;

  assign do_push = f.push && (cnt_r != (AW+1)'(DEPTH));
  assign do_pop  = f.pop && (cnt_r != '0);
  assign f.rdata = mem[rp_r];
  assign f.empty = (cnt_r == '0);
  assign f.full  = (cnt_r == (AW+1)'(DEPTH));

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wp_r] <= f.wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) wp_r <= AW'(wp_r + 1'b1);
      if (do_pop) rp_r <= AW'(rp_r + 1'b1);
      cnt_r <= (AW+1)'(cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop));
    end
  end
endmodule : usnb_fifo
`default_nettype wire

// ---- hw/usnb_ctrl.sv ----
// serial port ninth-bit, receive enable and mode 0 clock control with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "usnb_defs.svh"
module usnb_ctrl #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        mclk,          // system clock
  input  wire logic        rst,           // async reset, high
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic             pready,        // apb ready
  output logic [31:0]      prdata,        // apb read data
  output logic             pslverr,       // apb error, unmapped address or write to status or tx data
  input  wire logic        rx_done,       // receiver frame complete, one cycle
  input  wire logic [7:0]  rx_byte,       // received data byte
  input  wire logic        rx_bit9,       // received ninth or stop bit
  input  wire logic        tx_done,       // transmitter word sent, one cycle
  input  wire logic        tx_take,       // transmitter takes the presented word
  output logic             tx_valid,      // word ready for transmitter
  output logic [8:0]       tx_word,       // ninth bit and byte to send
  output usnb_pkg::usnb_mode_e mode,      // serial mode
  output logic             rx_enable,     // receiver may accept frames
  output logic             m0_start,      // mode 0 reception start pulse
  output logic             m0_clk_en,     // mode 0 shift clock enable
  output logic             irq            // level interrupt
);
  import usnb_pkg::*;

  logic [7:0]  ctrl_r;
  logic [1:0]  fcfg_r;
  logic [3:0]  stat_r;
  logic [3:0]  ien_r;
  logic [7:0]  rxbuf_r;
  logic [8:0]  txbuf_r;
  logic        txbuf_v_r;
  logic [3:0]  div_r;
  logic        ren_d_r;
  logic        wr_acc;
  logic        rd_acc;
  logic        accept;
  logic        drop;
  logic        fifo_rd;
  logic        data_wr;
  logic [3:0]  ev;
  logic [3:0]  div_top;
  usnb_mode_e  cur_mode;

  usnb_fifo_if rxf ();
  usnb_fifo_if txf ();

  usnb_fifo #(.DEPTH(FIFO_DEPTH)) u_rxf (.mclk(mclk), .rst(rst), .f(rxf));
  usnb_fifo #(.DEPTH(FIFO_DEPTH)) u_txf (.mclk(mclk), .rst(rst), .f(txf));

  assign cur_mode = usnb_mode_e'({ctrl_r[`USNB_BIT_SM0], ctrl_r[`USNB_BIT_SM1]});
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign data_wr  = wr_acc && (paddr == `USNB_ADDR_DATA);
  assign fifo_rd  = rd_acc && (paddr == `USNB_ADDR_DATA) && fcfg_r[`USNB_BIT_RXFEN];

  // frame filter; receiver gated by enable
  always_comb begin
    accept = 1'b0;
    drop   = 1'b0;
    if (rx_done && ctrl_r[`USNB_BIT_REN]) begin
      if (ctrl_r[`USNB_BIT_MPCHK] && (cur_mode == USNB_M1) && !rx_bit9) begin
        drop = 1'b1;
      end else if (ctrl_r[`USNB_BIT_MPCHK] && (cur_mode == USNB_M2 || cur_mode == USNB_M3)
                   && !rx_bit9) begin
        drop = 1'b1;
      end else begin
        accept = 1'b1;
      end
    end
  end

  assign rxf.push  = accept && fcfg_r[`USNB_BIT_RXFEN];
  assign rxf.wdata = {rx_bit9, rx_byte};
  assign rxf.pop   = fifo_rd;
  // ninth bit stored with each byte at buffer write
  assign txf.push  = data_wr && fcfg_r[`USNB_BIT_TXFEN];
  assign txf.wdata = {ctrl_r[`USNB_BIT_TX9], pwdata[7:0]};
  assign txf.pop   = tx_take && fcfg_r[`USNB_BIT_TXFEN] && !txf.empty;

  assign ev = {ren_d_r == 1'b0 && ctrl_r[`USNB_BIT_REN] && cur_mode == USNB_M0,
               tx_done, drop, accept};

  // control register; hardware sets win over software writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `USNB_CTRL_RESET;
    end else begin
      if (wr_acc && paddr == `USNB_ADDR_CTRL) begin
        ctrl_r <= pwdata[7:0];
      end
      if (fcfg_r[`USNB_BIT_RXFEN]) begin
        // flag follows oldest entry, moves on each buffer read
        ctrl_r[`USNB_BIT_RX9] <= rxf.empty ? 1'b0 : rxf.rdata[8];
      end else if (accept && cur_mode != USNB_M0) begin
        // once per frame; mode 0 leaves it untouched
        ctrl_r[`USNB_BIT_RX9] <= rx_bit9;
      end
      if (accept) ctrl_r[`USNB_BIT_RXFLAG] <= 1'b1;
      if (tx_done) ctrl_r[`USNB_BIT_TI] <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fcfg_r <= 2'h0;
      ien_r  <= 4'h0;
    end else begin
      if (wr_acc && paddr == `USNB_ADDR_FCFG) fcfg_r <= pwdata[1:0];
      if (wr_acc && paddr == `USNB_ADDR_IEN) ien_r <= pwdata[3:0];
    end
  end

  // sticky status; a new event beats the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat_r <= 4'h0;
    end else begin
      stat_r <= ((wr_acc && paddr == `USNB_ADDR_ICLR) ? (stat_r & ~pwdata[3:0]) : stat_r) | ev;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxbuf_r <= 8'h00;
    end else if (accept && !fcfg_r[`USNB_BIT_RXFEN]) begin
      rxbuf_r <= rx_byte;
    end
  end

  // single transmit holding word when fifo is off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txbuf_r   <= 9'h000;
      txbuf_v_r <= 1'b0;
    end else if (data_wr && !fcfg_r[`USNB_BIT_TXFEN]) begin
      txbuf_r   <= {ctrl_r[`USNB_BIT_TX9], pwdata[7:0]};
      txbuf_v_r <= 1'b1;
    end else if (tx_take) begin
      txbuf_v_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_word  <= 9'h000;
    end else begin
      if (tx_take) begin
        // a taken word must not be offered a second time
        tx_valid <= 1'b0;
      end else begin
        tx_valid <= fcfg_r[`USNB_BIT_TXFEN] ? !txf.empty : txbuf_v_r;
      end
      if (cur_mode == USNB_M2 || cur_mode == USNB_M3) begin
        // live bit when no fifo; fifo carries its own copy
        tx_word <= fcfg_r[`USNB_BIT_TXFEN] ? txf.rdata
                   : {ctrl_r[`USNB_BIT_TX9], txbuf_r[7:0]};
      end else begin
        tx_word <= {1'b0, fcfg_r[`USNB_BIT_TXFEN] ? txf.rdata[7:0] : txbuf_r[7:0]};
      end
    end
  end

  // mode 0 shift clock: divide by 12, or by 4 with check bit set
  assign div_top = ctrl_r[`USNB_BIT_MPCHK] ? `USNB_DIV4 : `USNB_DIV12;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r     <= 4'h0;
      m0_clk_en <= 1'b0;
    end else if (cur_mode != USNB_M0) begin
      div_r     <= 4'h0;
      m0_clk_en <= 1'b0;
    end else if (div_r >= div_top - 4'd1) begin
      div_r     <= 4'h0;
      m0_clk_en <= 1'b1;
    end else begin
      div_r     <= 4'(div_r + 4'd1);
      m0_clk_en <= 1'b0;
    end
  end

  // rising receive enable in mode 0 starts a reception
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ren_d_r   <= 1'b0;
      m0_start  <= 1'b0;
      rx_enable <= 1'b0;
      mode      <= USNB_M0;
      irq       <= 1'b0;
    end else begin
      ren_d_r   <= ctrl_r[`USNB_BIT_REN];
      m0_start  <= !ren_d_r && ctrl_r[`USNB_BIT_REN] && cur_mode == USNB_M0;
      rx_enable <= ctrl_r[`USNB_BIT_REN];
      mode      <= cur_mode;
      irq       <= |(stat_r & ien_r);
    end
  end

  // apb: zero wait states, unmapped addresses answer slverr
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `USNB_ADDR_CTRL:   prdata <= {24'h00_0000, ctrl_r};
          `USNB_ADDR_DATA:   prdata <= {24'h00_0000, fcfg_r[`USNB_BIT_RXFEN] ? rxf.rdata[7:0]
                                                                             : rxbuf_r};
          `USNB_ADDR_FCFG:   prdata <= {30'h0000_0000, fcfg_r};
          `USNB_ADDR_STAT:   prdata <= {28'h000_0000, stat_r};
          `USNB_ADDR_IEN:    prdata <= {28'h000_0000, ien_r};
          `USNB_ADDR_ICLR:   prdata <= 32'h0000_0000;
          `USNB_ADDR_TXDATA: prdata <= {23'h00_0000, tx_word};
          default:           pslverr <= psel && !penable;
        endcase
      end else if (psel && !penable) begin
        case (paddr)
          `USNB_ADDR_CTRL, `USNB_ADDR_DATA, `USNB_ADDR_FCFG, `USNB_ADDR_IEN,
          `USNB_ADDR_ICLR: pslverr <= 1'b0;
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : usnb_ctrl
`default_nettype wire

// ---- tb/usnb_ctrl_chk.sv ----
// port-level concurrent checks for the serial ninth-bit control block
`timescale 1ns/1ps
`default_nettype none
module usnb_ctrl_chk
  import usnb_pkg::*;
(
  input wire logic        mclk,      // clock
  input wire logic        rst,       // reset
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb enable
  input wire logic        pwrite,    // apb write
  input wire logic [11:0] paddr,     // apb address
  input wire logic [31:0] pwdata,    // apb data
  input wire logic        pready,    // apb ready
  input wire logic        pslverr,   // apb error
  input wire logic        tx_take,   // word taken
  input wire logic        tx_valid,  // word ready
  input wire logic [8:0]  tx_word,   // word out
  input wire usnb_pkg::usnb_mode_e mode, // mode
  input wire logic        rx_enable, // receive on
  input wire logic        m0_start,  // mode 0 start
  input wire logic        m0_clk_en  // shift clock
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic       wr_ctrl;
  logic [2:0] quiet_r;
  assign wr_ctrl = psel && penable && pwrite && paddr == 12'h000;
  // a register write may move the live ninth bit a few cycles later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      quiet_r <= 3'h0;
    else if (psel)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  apb_ready_a:
    assert property (psel && !penable |=> pready) else $error("ready missing");
  slverr_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  ren_on_a:
    assert property (wr_ctrl && pwdata[4] |-> ##[1:2] rx_enable) else $error("enable not set");
  ren_off_a:
    assert property (wr_ctrl && !pwdata[4] |-> ##[1:2] !rx_enable) else $error("enable stuck");
  start_cause_a:
    assert property (m0_start |-> mode == USNB_M0 && rx_enable) else $error("stray start");
  start_pulse_a:
    assert property (m0_start |=> !m0_start) else $error("start too long");
  clk_mode_a:
    assert property (m0_clk_en |-> mode == USNB_M0 || $past(mode) == USNB_M0)
      else $error("shift clock outside mode 0");
  clk_gap_a:
    assert property (m0_clk_en |=> !m0_clk_en [*3]) else $error("shift clock too fast");
  tx_hold_a:
    assert property (tx_valid && !tx_take |=> tx_valid) else $error("word lost");
  tx_stable_a:
    assert property (tx_valid && !tx_take && !$past(tx_take) && quiet_r >= 3'h4
      |=> $stable(tx_word)) else $error("word changed");
endmodule : usnb_ctrl_chk
bind usnb_ctrl usnb_ctrl_chk usnb_ctrl_chk_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .tx_take, .tx_valid, .tx_word, .mode, .rx_enable, .m0_start,
  .m0_clk_en);
`default_nettype wire

// ---- tb/usnb_node.sv ----
// remote serial node: delivers frames, takes transmit words
`timescale 1ns/1ps
`default_nettype none
module usnb_node (
  input  wire logic       mclk,     // clock
  output logic            rx_done,  // frame done
  output logic [7:0]      rx_byte,  // byte
  output logic            rx_bit9,  // ninth or stop
  output logic            tx_done,  // word sent
  output logic            tx_take,  // word taken
  input  wire logic       tx_valid, // word ready
  input  wire logic [8:0] tx_word   // word
);
  int         gap = 3;
  int         cnt = 0;
  logic [8:0] got[$];
  initial begin
    {rx_done, rx_byte, rx_bit9, tx_done, tx_take} = '0;
  end
  task automatic send(input logic [7:0] b, input logic n);
    @(posedge mclk);
    rx_done <= 1'b1;
    rx_byte <= b;
    rx_bit9 <= n;
    @(posedge mclk);
    rx_done <= 1'b0;
    // idle lines show the inverse so stale data never passes
    rx_byte <= ~b;
    rx_bit9 <= ~n;
  endtask : send
  // gap sets how slowly the far side drains words
  always @(posedge mclk) begin
    tx_take <= 1'b0;
    tx_done <= tx_take;
    cnt <= cnt + 1;
    if (tx_valid === 1'b1 && !tx_take && cnt >= gap) begin
      tx_take <= 1'b1;
      cnt <= 0;
      got.push_back(tx_word);
    end
  end
endmodule : usnb_node
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the serial ninth-bit control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usnb_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        rx_done, rx_bit9, tx_done, tx_take, tx_valid, rx_enable, m0_start, m0_clk_en, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  rx_byte;
  logic [8:0]  tx_word;
  usnb_mode_e  mode;
  int          fails = 0;
  int          cmp_count = 0;
  int          starts = 0;
  usnb_ctrl usnb_ctrl_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .rx_done, .rx_byte, .rx_bit9, .tx_done, .tx_take, .tx_valid, .tx_word,
    .mode, .rx_enable, .m0_start, .m0_clk_en, .irq);
  usnb_node usnb_node_inst (.mclk, .rx_done, .rx_byte, .rx_bit9, .tx_done, .tx_take,
    .tx_valid, .tx_word);
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdbit(input logic [11:0] a, input int b, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(32'(rd[b]), 32'(e));
  endtask : rdbit
  task automatic frame(input logic [7:0] b, input logic n);
    usnb_node_inst.send(b, n);
    repeat (3) @(posedge mclk);
  endtask : frame
  task automatic wait_tx(input int k);
    int n;
    for (n = 0; n < 500 && usnb_node_inst.got.size() < k; n++) @(posedge mclk);
    if (n >= 500) begin
      fails++;
      give_verdict();
    end
  endtask : wait_tx
  task automatic clk_gap(input int e);
    int n;
    for (n = 0; n < 40 && m0_clk_en !== 1'b1; n++) @(posedge mclk);
    @(posedge mclk);
    for (n = 1; n < 40 && m0_clk_en !== 1'b1; n++) @(posedge mclk);
    chk(n, e);
  endtask : clk_gap
  always @(posedge mclk) if (m0_start === 1'b1) starts++;
  task automatic t_reg();
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    wr(12'h018, 32'h0000_0001);
    chk(32'(err), 32'h0000_0001);
  endtask : t_reg
  task automatic t_rx_ninth();
    wr(12'h000, 32'h0000_0090);
    frame(8'hA5, 1'b1);
    rdbit(12'h000, 2, 1'b1);
    frame(8'h5A, 1'b0);
    rdbit(12'h000, 2, 1'b0);
    wr(12'h000, 32'h0000_0050);
    frame(8'h11, 1'b1);
    rdbit(12'h000, 2, 1'b1);
    wr(12'h000, 32'h0000_0014);
    frame(8'h22, 1'b0);
    rdbit(12'h000, 2, 1'b1);
  endtask : t_rx_ninth
  task automatic t_filter();
    wr(12'h014, 32'h0000_000F);
    wr(12'h000, 32'h0000_0070);
    frame(8'h33, 1'b0);
    rdbit(12'h00C, 1, 1'b1);
    rdbit(12'h000, 0, 1'b0);
    wr(12'h010, 32'h0000_0001);
    wr(12'h000, 32'h0000_00B0);
    frame(8'h44, 1'b0);
    chk(32'(irq), 32'h0000_0000);
    frame(8'h45, 1'b1);
    chk(32'(irq), 32'h0000_0001);
    wr(12'h000, 32'h0000_00F0);
    frame(8'h46, 1'b0);
    rdbit(12'h000, 0, 1'b0);
    frame(8'h47, 1'b1);
    rdbit(12'h000, 0, 1'b1);
    wr(12'h010, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0000_0000);
    wr(12'h010, 32'h0000_0001);
    wr(12'h014, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0000_0000);
    wr(12'h000, 32'h0000_0080);
    frame(8'h66, 1'b1);
    rdbit(12'h00C, 0, 1'b0);
  endtask : t_filter
  task automatic t_rxfifo();
    wr(12'h008, 32'h0000_0001);
    wr(12'h000, 32'h0000_0090);
    frame(8'h01, 1'b1);
    frame(8'h02, 1'b0);
    rdbit(12'h000, 2, 1'b1);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_00FF, 32'h0000_0001);
    rdbit(12'h000, 2, 1'b0);
    apb(1'b0, 12'h004, 32'h0000_0000);
  endtask : t_rxfifo
  task automatic t_tx();
    usnb_node_inst.gap = 30;
    wr(12'h008, 32'h0000_0000);
    wr(12'h000, 32'h0000_0088);
    wr(12'h004, 32'h0000_003C);
    wait_tx(1);
    chk(32'(usnb_node_inst.got[0]), 32'h0000_013C);
    wr(12'h008, 32'h0000_0002);
    wr(12'h004, 32'h0000_0011);
    wr(12'h004, 32'h0000_0012);
    wr(12'h000, 32'h0000_0080);
    wr(12'h004, 32'h0000_0022);
    wait_tx(4);
    chk(32'(usnb_node_inst.got[2]), 32'h0000_0112);
    chk(32'(usnb_node_inst.got[3]), 32'h0000_0022);
  endtask : t_tx
  task automatic t_mode0();
    wr(12'h000, 32'h0000_0000);
    starts = 0;
    wr(12'h000, 32'h0000_0010);
    repeat (3) @(posedge mclk);
    chk(starts, 1);
    clk_gap(12);
    wr(12'h000, 32'h0000_0030);
    clk_gap(4);
  endtask : t_mode0
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reg();
    t_rx_ninth();
    t_filter();
    t_rxfifo();
    t_tx();
    t_mode0();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
